//--- acc_pkg.sv
// shared constants for the analog comparator control block
package acc_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFF_CTRL0_C1 = 4'h0;
   localparam logic [3:0] OFF_CTRL1_C1 = 4'h1;
   localparam logic [3:0] OFF_CTRL0_C2 = 4'h2;
   localparam logic [3:0] OFF_CTRL1_C2 = 4'h3;
   localparam logic [3:0] OFF_MIRROR = 4'h4;
   localparam logic [3:0] OFF_IRQ = 4'h5;
   // control register 0 field positions
   localparam int B_ENABLE = 7;
   localparam int B_RESULT = 6;
   localparam int B_PIN_EN = 5;
   localparam int B_POLARITY = 4;
   localparam int B_SPEED = 2;
   localparam int B_HYST = 1;
   localparam int B_SYNC = 0;
   // control register 1 field positions
   localparam int B_RISE_IE = 7;
   localparam int B_FALL_IE = 6;
   localparam int B_PCH_LO = 4;
   localparam int B_NCH_LO = 0;
   // irq register field positions
   localparam int B_FLAG1 = 0;
   localparam int B_FLAG2 = 1;
   localparam int B_IE1 = 2;
   localparam int B_IE2 = 3;
   localparam int B_PERIPHERAL_IRQ_ENABLE = 4;
   localparam int B_GIE = 5;
   // reset values and write masks
   localparam logic [7:0] RST_CTRL0 = 8'h04;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_IRQ = 8'h00;
   localparam logic [7:0] WMASK_CTRL0 = 8'hB7;
   localparam logic [7:0] WMASK_CTRL1 = 8'hF7;
   // negative channel codes
   localparam logic [2:0] NCH_FIXED = 3'h4;
endpackage : acc_pkg

//--- acc_channel.sv
// one comparator channel: polarity, enable gating, sampling, edges and sync latch
module acc_channel
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic rawCompare,
   input wire logic compEnable,
   input wire logic resultPolarity,
   input wire logic timerSyncEnable,
   input wire logic timerClockSync,
   input wire logic risingIrqEnable,
   input wire logic fallingIrqEnable,
   output logic comparatorResult,
   output logic pinResult,
   output logic edgeEvent
);
   logic rawMeta_r;
   logic rawSync_r;
   logic prevResult_r;
   logic tclkPrev_r;
   logic syncResult_r;
   logic liveResult;
   logic risingEdge;
   logic fallingEdge;
   logic timerFall;

   // raw analog decision crosses in through two flip-flops
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         rawMeta_r <= 1'b0;
         rawSync_r <= 1'b0;
      end
      else
      begin
         rawMeta_r <= rawCompare;
         rawSync_r <= rawMeta_r;
      end
   end

   // forced low while disabled, then polarity applied
   assign liveResult = (compEnable & rawSync_r) ^ resultPolarity;

   // result bit sampled once per instruction cycle
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         comparatorResult <= 1'b0;
         prevResult_r <= 1'b0;
      end
      else
      begin
         comparatorResult <= liveResult;
         prevResult_r <= comparatorResult;
      end
   end

   // edges from current and previous samples, any cause counts
   assign risingEdge = comparatorResult & ~prevResult_r;
   assign fallingEdge = ~comparatorResult & prevResult_r;
   assign edgeEvent = (risingEdge & risingIrqEnable) | (fallingEdge & fallingIrqEnable);

   // capture on falling edge of the prescaled timer clock
   assign timerFall = tclkPrev_r & ~timerClockSync;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         tclkPrev_r <= 1'b0;
         syncResult_r <= 1'b0;
      end
      else
      begin
         tclkPrev_r <= timerClockSync;
         if (timerFall)
         begin
            syncResult_r <= liveResult;
         end
      end
   end

   // pin/timer output: latched or pass-through
   assign pinResult = timerSyncEnable ? syncResult_r : liveResult;
endmodule : acc_channel

//--- acc_top.sv
// control and status logic around two analog comparators
// How it works
// - speed bit resets one; zero is low-power
// - hysteresis bit adds hysteresis, resets zero
// - sync set: latch output on timer fall
// - sync clear: output passes unlatched
// - timer counts on rising, latch on falling
// - rising edge sets flag when enabled
// - falling edge sets flag when enabled
// - software clears flag; edge wins clear
// - polarity or enable toggles also set flag
// - interrupt needs channel, peripheral, global enables
// - polarity one inverts the raw comparison
// - pin enable drives result regardless enable
// - enable bit seven; zero disconnects inputs
// - negative select: four pins, fixed, reserved
// - analog pins read zero on port
// - disabled comparator output forced to the polarity bit
// - result sampled every instruction cycle
// - mirror register holds both results
module acc_top
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire logic [1:0] rawCompare,
   input wire logic timerClock,
   input wire logic [7:0] portPins,
   input wire logic [7:0] analogPinSelect,
   output logic [7:0] portReadValue,
   output logic [1:0] comparatorOn,
   output logic [1:0] speedPowerSelect,
   output logic [1:0] hysteresisEnable,
   output logic [1:0] [1:0] positiveChannelSelect,
   output logic [1:0] [2:0] negativeChannelSelect,
   output logic [1:0] pinResult,
   output logic [1:0] pinOutEnable,
   output logic [1:0] timerGateResult,
   output logic irqRequest
);
   logic [7:0] ctrl0C1_r;
   logic [7:0] ctrl1C1_r;
   logic [7:0] ctrl0C2_r;
   logic [7:0] ctrl1C2_r;
   logic [7:0] irq_r;
   logic [7:0] irq_nxt;
   logic [7:0] portSync1_r;
   logic [7:0] portSync2_r;
   logic tclkMeta_r;
   logic tclkSync_r;
   logic [1:0] result;
   logic [1:0] edgeEvent;
   logic [1:0] pinRes;
   logic [7:0] ctrl0C1View;
   logic [7:0] ctrl0C2View;

   // timer clock pin through two flip-flops
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         tclkMeta_r <= 1'b0;
         tclkSync_r <= 1'b0;
      end
      else
      begin
         tclkMeta_r <= timerClock;
         tclkSync_r <= tclkMeta_r;
      end
   end

   // comparator one channel
   acc_channel u_ch1
   (
      .clk(clk),
      .rstn(rstn),
      .rawCompare(rawCompare[0]),
      .compEnable(ctrl0C1_r[acc_pkg::B_ENABLE]),
      .resultPolarity(ctrl0C1_r[acc_pkg::B_POLARITY]),
      .timerSyncEnable(ctrl0C1_r[acc_pkg::B_SYNC]),
      .timerClockSync(tclkSync_r),
      .risingIrqEnable(ctrl1C1_r[acc_pkg::B_RISE_IE]),
      .fallingIrqEnable(ctrl1C1_r[acc_pkg::B_FALL_IE]),
      .comparatorResult(result[0]),
      .pinResult(pinRes[0]),
      .edgeEvent(edgeEvent[0])
   );

   // comparator two channel
   acc_channel u_ch2
   (
      .clk(clk),
      .rstn(rstn),
      .rawCompare(rawCompare[1]),
      .compEnable(ctrl0C2_r[acc_pkg::B_ENABLE]),
      .resultPolarity(ctrl0C2_r[acc_pkg::B_POLARITY]),
      .timerSyncEnable(ctrl0C2_r[acc_pkg::B_SYNC]),
      .timerClockSync(tclkSync_r),
      .risingIrqEnable(ctrl1C2_r[acc_pkg::B_RISE_IE]),
      .fallingIrqEnable(ctrl1C2_r[acc_pkg::B_FALL_IE]),
      .comparatorResult(result[1]),
      .pinResult(pinRes[1]),
      .edgeEvent(edgeEvent[1])
   );

   // control register writes, read-only and unused bits masked
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl0C1_r <= acc_pkg::RST_CTRL0;
         ctrl0C2_r <= acc_pkg::RST_CTRL0;
         ctrl1C1_r <= acc_pkg::RST_CTRL1;
         ctrl1C2_r <= acc_pkg::RST_CTRL1;
      end
      else if (regWrite)
      begin
         if (regAddr == acc_pkg::OFF_CTRL0_C1)
         begin
            ctrl0C1_r <= regWdata & acc_pkg::WMASK_CTRL0;
         end
         else if (regAddr == acc_pkg::OFF_CTRL1_C1)
         begin
            ctrl1C1_r <= regWdata & acc_pkg::WMASK_CTRL1;
         end
         else if (regAddr == acc_pkg::OFF_CTRL0_C2)
         begin
            ctrl0C2_r <= regWdata & acc_pkg::WMASK_CTRL0;
         end
         else if (regAddr == acc_pkg::OFF_CTRL1_C2)
         begin
            ctrl1C2_r <= regWdata & acc_pkg::WMASK_CTRL1;
         end
      end
   end

   // irq flags and enables; an edge wins over a software clear
   always_comb
   begin
      irq_nxt = irq_r;
      if (regWrite && regAddr == acc_pkg::OFF_IRQ)
      begin
         irq_nxt = regWdata & 8'h3F;
      end
      if (edgeEvent[0])
      begin
         irq_nxt[acc_pkg::B_FLAG1] = 1'b1;
      end
      if (edgeEvent[1])
      begin
         irq_nxt[acc_pkg::B_FLAG2] = 1'b1;
      end
   end

   // irq register
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         irq_r <= acc_pkg::RST_IRQ;
      end
      else
      begin
         irq_r <= irq_nxt;
      end
   end

   // interrupt needs flag and channel, peripheral and global enables
   assign irqRequest = irq_r[acc_pkg::B_GIE] & irq_r[acc_pkg::B_PERIPHERAL_IRQ_ENABLE]
      & ((irq_r[acc_pkg::B_FLAG1] & irq_r[acc_pkg::B_IE1])
      | (irq_r[acc_pkg::B_FLAG2] & irq_r[acc_pkg::B_IE2]));

   // status views with live result bit
   always_comb
   begin
      ctrl0C1View = ctrl0C1_r;
      ctrl0C1View[acc_pkg::B_RESULT] = result[0];
      ctrl0C2View = ctrl0C2_r;
      ctrl0C2View[acc_pkg::B_RESULT] = result[1];
   end

   // register read data one cycle after the read strobe
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         regRdata <= 8'h00;
      end
      else if (regRead)
      begin
         if (regAddr == acc_pkg::OFF_CTRL0_C1)
         begin
            regRdata <= ctrl0C1View;
         end
         else if (regAddr == acc_pkg::OFF_CTRL1_C1)
         begin
            regRdata <= ctrl1C1_r;
         end
         else if (regAddr == acc_pkg::OFF_CTRL0_C2)
         begin
            regRdata <= ctrl0C2View;
         end
         else if (regAddr == acc_pkg::OFF_CTRL1_C2)
         begin
            regRdata <= ctrl1C2_r;
         end
         else if (regAddr == acc_pkg::OFF_MIRROR)
         begin
            regRdata <= {6'h00, result[1], result[0]};
         end
         else if (regAddr == acc_pkg::OFF_IRQ)
         begin
            regRdata <= irq_r;
         end
         else
         begin
            regRdata <= 8'h00;
         end
      end
      else
      begin
         regRdata <= 8'h00;
      end
   end

   // port pins synchronised, analog pins read as zero
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         portSync1_r <= 8'h00;
         portSync2_r <= 8'h00;
         portReadValue <= 8'h00;
      end
      else
      begin
         portSync1_r <= portPins;
         portSync2_r <= portSync1_r;
         portReadValue <= portSync2_r & ~analogPinSelect;
      end
   end

   // analog configuration toward the comparators; inputs cut while disabled
   always_comb
   begin
      comparatorOn = {ctrl0C2_r[acc_pkg::B_ENABLE], ctrl0C1_r[acc_pkg::B_ENABLE]};
      speedPowerSelect = {ctrl0C2_r[acc_pkg::B_SPEED], ctrl0C1_r[acc_pkg::B_SPEED]};
      hysteresisEnable = {ctrl0C2_r[acc_pkg::B_HYST], ctrl0C1_r[acc_pkg::B_HYST]};
      positiveChannelSelect[0] = ctrl1C1_r[acc_pkg::B_PCH_LO +: 2];
      positiveChannelSelect[1] = ctrl1C2_r[acc_pkg::B_PCH_LO +: 2];
      negativeChannelSelect[0] = ctrl1C1_r[acc_pkg::B_NCH_LO +: 3];
      negativeChannelSelect[1] = ctrl1C2_r[acc_pkg::B_NCH_LO +: 3];
   end

   // pin and timer-gate outputs; pin enable independent of comparator enable
   assign pinResult = pinRes;
   assign timerGateResult = pinRes;
   assign pinOutEnable = {ctrl0C2_r[acc_pkg::B_PIN_EN], ctrl0C1_r[acc_pkg::B_PIN_EN]};

   // assertions
   property p_speed_reset;
      @(posedge clk) $rose(rstn) |-> speedPowerSelect == 2'b11 && hysteresisEnable == 2'b00;
   endproperty
   a_speed_reset: assert property (p_speed_reset) else $error("speed/hyst reset wrong");

   property p_hyst_follow;
      @(posedge clk) disable iff (!rstn)
      regWrite && regAddr == acc_pkg::OFF_CTRL0_C1
      |=> hysteresisEnable[0] == $past(regWdata[acc_pkg::B_HYST]);
   endproperty
   a_hyst_follow: assert property (p_hyst_follow) else $error("hysteresis not written");

   property p_async_pass;
      @(posedge clk) disable iff (!rstn)
      !ctrl0C1_r[acc_pkg::B_SYNC] |-> pinResult[0] == ((ctrl0C1_r[acc_pkg::B_ENABLE]
         & u_ch1.rawSync_r) ^ ctrl0C1_r[acc_pkg::B_POLARITY]);
   endproperty
   a_async_pass: assert property (p_async_pass) else $error("async pin path wrong");

   property p_sync_hold;
      @(posedge clk) disable iff (!rstn)
      ctrl0C1_r[acc_pkg::B_SYNC] && $past(ctrl0C1_r[acc_pkg::B_SYNC]) && !$past(u_ch1.timerFall)
      |-> $stable(pinResult[0]);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync output moved off edge");

   property p_rise_flag;
      @(posedge clk) disable iff (!rstn)
      $rose(result[0]) && ctrl1C1_r[acc_pkg::B_RISE_IE] |=> irq_r[acc_pkg::B_FLAG1];
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("rising edge lost");

   property p_fall_flag;
      @(posedge clk) disable iff (!rstn)
      $fell(result[1]) && ctrl1C2_r[acc_pkg::B_FALL_IE] |=> irq_r[acc_pkg::B_FLAG2];
   endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("falling edge lost");

   property p_no_spurious;
      @(posedge clk) disable iff (!rstn)
      !irq_r[acc_pkg::B_FLAG1] && !(regWrite && regAddr == acc_pkg::OFF_IRQ)
      && $stable(result[0]) ##1 $stable(result[0]) |-> !irq_r[acc_pkg::B_FLAG1];
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("flag set without edge");

   property p_irq_gate;
      @(posedge clk) disable iff (!rstn)
      irqRequest |-> irq_r[acc_pkg::B_GIE] && irq_r[acc_pkg::B_PERIPHERAL_IRQ_ENABLE];
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without global enables");

   // an enabled edge sets the flag even while software clears it
   property p_edge_wins;
      @(posedge clk) disable iff (!rstn)
      edgeEvent[0] |=> irq_r[acc_pkg::B_FLAG1];
   endproperty
   a_edge_wins: assert property (p_edge_wins) else $error("edge lost to flag clear");

   property p_disabled_zero;
      @(posedge clk) disable iff (!rstn)
      (!ctrl0C1_r[acc_pkg::B_ENABLE] && !ctrl0C1_r[acc_pkg::B_POLARITY]) [*3] |-> !result[0];
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("disabled output not zero");

   property p_mirror;
      @(posedge clk) disable iff (!rstn)
      regRead && regAddr == acc_pkg::OFF_MIRROR |=> regRdata == {6'h00, $past(result)};
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror register wrong");

   property p_analog_zero;
      @(posedge clk) disable iff (!rstn)
      ##1 (portReadValue & $past(analogPinSelect)) == 8'h00;
   endproperty
   a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

   c_irq: cover property (@(posedge clk) disable iff (!rstn) $rose(irqRequest));
   c_sync: cover property (@(posedge clk) disable iff (!rstn)
      ctrl0C1_r[acc_pkg::B_SYNC] && u_ch1.timerFall);
   c_clear_race: cover property (@(posedge clk) disable iff (!rstn)
      edgeEvent[0] && regWrite && regAddr == acc_pkg::OFF_IRQ);
endmodule : acc_top

//--- acc_analog_model.sv
// far-side model: comparator decisions, timer-1 clock and port pin levels
module acc_analog_model
(
   input wire logic clk,
   input wire logic [1:0] rawSet,
   input wire logic timerRun,
   input wire logic [7:0] pinSet,
   output logic [1:0] rawCompare,
   output logic timerClock,
   output logic [7:0] portPins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] divCnt;
   // decisions and pin levels follow the commanded values
   assign rawCompare = rawSet;
   assign portPins = pinSet;
   // prescaled timer clock of sixteen clk periods, stands low while stopped
   always_ff @(posedge clk)
   begin
      if (!timerRun)
      begin
         divCnt <= 3'h0;
         timerClock <= 1'b0;
      end
      else
      begin
         divCnt <= divCnt + 3'h1;
         if (divCnt == 3'h3)
         begin
            timerClock <= ~timerClock; // falling edges latch, rising edges count
         end
      end
   end
endmodule : acc_analog_model

//--- testbench.sv
// self-checking testbench for the comparator control block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] c0a = acc_pkg::OFF_CTRL0_C1;
   localparam logic [3:0] c1a = acc_pkg::OFF_CTRL1_C1;
   localparam logic [3:0] c0b = acc_pkg::OFF_CTRL0_C2;
   localparam logic [3:0] c1b = acc_pkg::OFF_CTRL1_C2;
   localparam logic [3:0] mir = acc_pkg::OFF_MIRROR;
   localparam logic [3:0] irq = acc_pkg::OFF_IRQ;
   logic clk, rstn, regWrite, regRead, timerRun, timerClock, irqRequest;
   logic [3:0] regAddr;
   logic [7:0] regWdata, regRdata, analogPinSelect, pinSet, portPins, portReadValue, rv;
   logic [1:0] rawSet, rawCompare, comparatorOn, speedPowerSelect, hysteresisEnable;
   logic [1:0] pinResult, pinOutEnable, timerGateResult;
   logic [1:0] [1:0] posSel;
   logic [1:0] [2:0] negSel;
   int failures, nChecks;
   // far side and device under test
   acc_analog_model model (.clk(clk), .rawSet(rawSet), .timerRun(timerRun), .pinSet(pinSet),
      .rawCompare(rawCompare), .timerClock(timerClock), .portPins(portPins));
   acc_top DUT (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rawCompare(rawCompare),
      .timerClock(timerClock), .portPins(portPins), .analogPinSelect(analogPinSelect),
      .portReadValue(portReadValue), .comparatorOn(comparatorOn),
      .speedPowerSelect(speedPowerSelect), .hysteresisEnable(hysteresisEnable),
      .positiveChannelSelect(posSel), .negativeChannelSelect(negSel), .pinResult(pinResult),
      .pinOutEnable(pinOutEnable), .timerGateResult(timerGateResult), .irqRequest(irqRequest));
   // compare and count
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one-cycle register write
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   // one-cycle register read, data taken in the following cycle
   task rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      rv = regRdata;
      chk(what, rv, exp);
   endtask : rdc
   // new analog decision, then let it pass sync, sample and edge stages
   task raw(input logic [1:0] v);
      @(posedge clk);
      rawSet <= v;
      repeat (6) @(posedge clk);
   endtask : raw
   // verdict and end of run
   task end_sim();
      $display("checks %0d failures %0d", nChecks, failures);
      if (failures == 0 && nChecks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // clock of 50 ns
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // watchdog
   initial
   begin
      #1000000;
      failures++;
      end_sim();
   end
   // main sequence
   initial
   begin
      {rstn, regWrite, regRead, timerRun, regAddr, regWdata, rawSet} = '0;
      analogPinSelect = 8'h00;
      pinSet = 8'h00;
      failures = 0;
      nChecks = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rdc("ctrl0 c1 reset", c0a, 8'h04);
      rdc("ctrl0 c2 reset", c0b, 8'h04);
      rdc("ctrl1 c1 reset", c1a, 8'h00);
      rdc("mirror reset", mir, 8'h00);
      rdc("unmapped read", 4'hF, 8'h00);
      chk("speed out", {6'h0, speedPowerSelect}, 8'h03);
      wr(c0a, 8'h02);
      rdc("ctrl0 speed low", c0a, 8'h02);
      chk("speed hyst out", {4'h0, speedPowerSelect, hysteresisEnable}, 8'h09);
      $display("test reset and config done");
      for (int p = 0; p < 4; p++)
         for (int n = 0; n < 8; n++)
         begin
            wr(c1a, {2'b00, p[1:0], 1'b1, n[2:0]});
            rdc("ctrl1 select", c1a, {2'b00, p[1:0], 1'b0, n[2:0]});
            chk("pos sel", {6'h0, posSel[0]}, {6'h0, p[1:0]});
            chk("neg sel", {5'h0, negSel[0]}, {5'h0, n[2:0]});
         end
      wr(c1a, 8'h00);
      $display("test channel select done");
      raw(2'b11);
      wr(c0a, 8'hC0);
      wr(c0b, 8'h80);
      repeat (6) @(posedge clk);
      rdc("ctrl0 c1 result", c0a, 8'hC0);
      rdc("mirror both", mir, 8'h03);
      chk("enable out", {6'h0, comparatorOn}, 8'h03);
      wr(c0a, 8'h90);
      repeat (6) @(posedge clk);
      rdc("ctrl0 inverted", c0a, 8'h90);
      chk("pin live", {4'h0, pinResult, timerGateResult}, 8'h0A);
      wr(c0a, 8'h20);
      wr(c0b, 8'h00);
      repeat (6) @(posedge clk);
      rdc("ctrl0 disabled", c0a, 8'h20);
      chk("pin enable", {6'h0, pinOutEnable}, 8'h01);
      $display("test result path done");
      wr(c0a, 8'h81);
      raw(2'b00);
      timerRun <= 1'b1;
      repeat (40) @(posedge clk);
      timerRun <= 1'b0;
      repeat (6) @(posedge clk);
      raw(2'b01);
      repeat (10) @(posedge clk);
      #1;
      chk("sync held", {7'h0, pinResult[0]}, 8'h00);
      rdc("sync internal", c0a, 8'hC1);
      timerRun <= 1'b1;
      repeat (40) @(posedge clk);
      timerRun <= 1'b0;
      #1;
      chk("sync latched", {4'h0, pinResult, timerGateResult}, 8'h05);
      wr(c0a, 8'h80);
      raw(2'b00);
      #1;
      chk("async follow", {7'h0, pinResult[0]}, 8'h00);
      $display("test sync done");
      wr(c1a, 8'h80);
      wr(irq, 8'h34);
      #1;
      chk("irq idle", {7'h0, irqRequest}, 8'h00);
      raw(2'b01);
      rdc("flag rise", irq, 8'h35);
      chk("irq raised", {7'h0, irqRequest}, 8'h01);
      wr(irq, 8'h14);
      rdc("flag cleared", irq, 8'h14);
      raw(2'b00);
      rdc("fall masked", irq, 8'h14);
      wr(c1a, 8'h40);
      raw(2'b01);
      rdc("rise masked", irq, 8'h14);
      raw(2'b00);
      rdc("flag fall", irq, 8'h15);
      chk("irq no global", {7'h0, irqRequest}, 8'h00);
      wr(c0a, 8'h00);
      wr(c1a, 8'h80);
      wr(irq, 8'h00);
      wr(c0a, 8'h10);
      repeat (4) @(posedge clk);
      rdc("flag polarity", irq, 8'h01);
      // polarity edge lands in the same cycle as a flag clear
      wr(c0a, 8'h00);
      wr(c0a, 8'h10);
      wr(irq, 8'h00);
      repeat (2) @(posedge clk);
      rdc("edge beats clear", irq, 8'h01);
      // second comparator: selects, masked rise, enabled fall, its own enable
      wr(c1b, 8'h65);
      rdc("ctrl1 c2 select", c1b, 8'h65);
      chk("pos sel c2", {6'h0, posSel[1]}, 8'h02);
      chk("neg sel c2", {5'h0, negSel[1]}, 8'h05);
      wr(c0b, 8'h10);
      wr(c0b, 8'h00);
      repeat (4) @(posedge clk);
      rdc("flag fall c2", irq, 8'h03);
      wr(irq, 8'h3A);
      #1;
      chk("irq c2", {7'h0, irqRequest}, 8'h01);
      $display("test interrupt done");
      // reset again in mid run
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rdc("ctrl0 c1 rerun", c0a, 8'h04);
      rdc("ctrl1 c2 rerun", c1b, 8'h00);
      rdc("irq rerun", irq, 8'h00);
      $display("test mid reset done");
      @(posedge clk);
      pinSet <= 8'hA5;
      analogPinSelect <= 8'h0F;
      repeat (5) @(posedge clk);
      #1;
      chk("port read", portReadValue, 8'hA0);
      $display("test port read done");
      end_sim();
   end
endmodule : testbench
